// file: hw/count_type_homing.sv
// Count type homing sequencer of a servo drive.
// Assumes all inputs synchronous to core_clk; move_step pulses once
// per unit of travel in the commanded direction.
//
// What this block does
// - Method value 1 selects count type homing
// - After dog front, travel distance, then Z
// - Dog held 10ms makes any length work
// - Homing speed until dog is detected
// - Creep speed after the dog is detected
// - Nonzero shift offsets home past that Z
// - Completion loads home address into position
// - Use point table 1 accel/decel times
// - Direction 0 increments, 1 decrements address
// - Polarity 0: dog off detects; 1: on
`timescale 1ns/1ps
`include "homing_cfg.svh"

module count_type_homing
#(
   parameter int DOG_MIN_CYCLES = `DOG_MIN_MS * `CYCLES_PER_MS
)
(
   // Clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   // Host mode selection and start
   input  wire homing_pkg::mode_select_type   mode_select,
   input  wire logic                          start,
   // Parameters and point table 1
   input  wire homing_pkg::homing_param_type  params,
   input  wire homing_pkg::accel_decel_type   table_one,
   // Machine feedback
   input  wire logic                          dog_in,
   input  wire logic                          z_pulse,
   input  wire logic                          move_step,
   // Command and status
   output homing_pkg::motion_cmd_type         motion_cmd_ff,
   output logic [31:0]                        current_position_ff,
   output logic                               homing_complete_flag_ff,
   output logic                               homing_busy_ff,
   output logic                               homing_error_ff
);
   import homing_pkg::*;

   // ******************************************
   // Helpers
   // ******************************************
   function automatic logic reached(input logic [31:0] cnt,
                                    input logic [31:0] target);
      reached = (cnt >= target);
   endfunction

   logic dog_front;
   logic dog_short;

   dog_qualifier
   #(
      .DOG_MIN_CYCLES (DOG_MIN_CYCLES)
   )
   u_dog
   (
      .core_clk             (core_clk),
      .rst                  (rst),
      .dog_in               (dog_in),
      .input_polarity_param (params.input_polarity_param),
      .dog_front_ff         (dog_front),
      .dog_short_ff         (dog_short)
   );

   // ******************************************
   // Sequencer
   // ******************************************
   homing_state_type state_ff;
   homing_state_type nxt_state;
   logic [31:0]      dist_ff;
   logic [31:0]      nxt_dist;
   motion_cmd_type   nxt_motion_cmd;
   logic [31:0]      nxt_current_position;
   logic             nxt_homing_complete_flag;
   logic             nxt_homing_busy;
   logic             nxt_homing_error;
   logic             manual_home_sel;
   logic             go;

   always_comb
   begin
      manual_home_sel = mode_select.auto_manual_select
                      & ~|mode_select.point_table_select_low
                      & ~|mode_select.point_table_select_high;
      go = start & manual_home_sel
         & (params.homing_method_param == `METHOD_COUNT_TYPE);
      nxt_state                = state_ff;
      nxt_dist                 = dist_ff;
      nxt_motion_cmd           = motion_cmd_ff;
      nxt_current_position     = current_position_ff;
      nxt_homing_complete_flag = homing_complete_flag_ff;
      nxt_homing_busy          = homing_busy_ff;
      nxt_homing_error         = homing_error_ff;
      if (move_step)
      begin
         if (motion_cmd_ff.direction == `DIR_INCREMENT)
            nxt_current_position = current_position_ff + `POS_STEP;
         else
            nxt_current_position = current_position_ff - `POS_STEP;
      end
      unique case (state_ff)
         ST_IDLE:
         begin
            if (go)
            begin
               nxt_state                = ST_FAST;
               nxt_homing_complete_flag = 1'b0;
               nxt_homing_busy          = 1'b1;
               nxt_homing_error         = 1'b0;
               nxt_motion_cmd.run       = 1'b1;
               nxt_motion_cmd.direction = params.homing_direction_param;
               nxt_motion_cmd.speed     = params.homing_speed_param;
               nxt_motion_cmd.accel_time = table_one.accel_time;
               nxt_motion_cmd.decel_time = table_one.decel_time;
            end
         end
         ST_FAST:
         begin
            if (dog_front)
            begin
               nxt_state            = ST_TRAVEL;
               nxt_dist             = `TRAVEL_ZERO;
               nxt_motion_cmd.speed = params.creep_speed_param;
            end
         end
         ST_TRAVEL:
         begin
            if (reached(dist_ff, params.post_dog_travel_param))
               nxt_state = ST_WAIT_Z;
            else if (move_step)
               nxt_dist = dist_ff + `POS_STEP;
         end
         ST_WAIT_Z:
         begin
            if (z_pulse)
            begin
               nxt_dist = `TRAVEL_ZERO;
               if (params.home_shift_param == `TRAVEL_ZERO)
                  nxt_state = ST_IDLE;
               else
                  nxt_state = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (reached(dist_ff, params.home_shift_param))
               nxt_state = ST_IDLE;
            else if (move_step)
               nxt_dist = dist_ff + `POS_STEP;
         end
      endcase
      // Home reached: stop, load address, raise the flag
      if ((state_ff == ST_WAIT_Z && z_pulse &&
           params.home_shift_param == `TRAVEL_ZERO) ||
          (state_ff == ST_SHIFT &&
           reached(dist_ff, params.home_shift_param)))
      begin
         nxt_motion_cmd.run       = 1'b0;
         nxt_motion_cmd.speed     = `SPEED_STOP;
         nxt_current_position     = params.home_address_param;
         nxt_homing_complete_flag = 1'b1;
         nxt_homing_busy          = 1'b0;
      end
      // A dog shorter than the minimum cannot be trusted
      if (dog_short && state_ff != ST_IDLE && state_ff != ST_FAST)
      begin
         nxt_state            = ST_IDLE;
         nxt_motion_cmd.run   = 1'b0;
         nxt_motion_cmd.speed = `SPEED_STOP;
         nxt_homing_busy      = 1'b0;
         nxt_homing_error     = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_ff                <= ST_IDLE;
         dist_ff                 <= `TRAVEL_ZERO;
         motion_cmd_ff           <= '0;
         current_position_ff     <= `TRAVEL_ZERO;
         homing_complete_flag_ff <= 1'b0;
         homing_busy_ff          <= 1'b0;
         homing_error_ff         <= 1'b0;
      end
      else
      begin
         state_ff                <= nxt_state;
         dist_ff                 <= nxt_dist;
         motion_cmd_ff           <= nxt_motion_cmd;
         current_position_ff     <= nxt_current_position;
         homing_complete_flag_ff <= nxt_homing_complete_flag;
         homing_busy_ff          <= nxt_homing_busy;
         homing_error_ff         <= nxt_homing_error;
      end
   end

   // ******************************************
   // Checks
   // ******************************************
   a_method_gate: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == ST_IDLE && start &&
       params.homing_method_param != `METHOD_COUNT_TYPE)
      |=> state_ff == ST_IDLE)
      else $error("homing started with another method selected");

   a_manual_gate: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == ST_IDLE && $rose(homing_busy_ff) == 1'b0 &&
       !manual_home_sel) |=> !$rose(homing_busy_ff))
      else $error("homing started outside manual home mode");

   a_fast_speed: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == ST_FAST) |->
      motion_cmd_ff.speed == params.homing_speed_param)
      else $error("speed before dog is not the homing speed");

   a_creep_speed: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == ST_FAST && dog_front) |=>
      motion_cmd_ff.speed == params.creep_speed_param)
      else $error("speed after dog is not the creep speed");

   a_travel_first: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == ST_TRAVEL &&
       !reached(dist_ff, params.post_dog_travel_param))
      |=> state_ff != ST_WAIT_Z || $past(reached(dist_ff,
          params.post_dog_travel_param)))
      else $error("Z search began before travel distance");

   a_home_load: assert property (@(posedge core_clk) disable iff (rst)
      $rose(homing_complete_flag_ff) |->
      current_position_ff == params.home_address_param)
      else $error("home address not loaded at completion");

   a_busy_flag: assert property (@(posedge core_clk) disable iff (rst)
      homing_busy_ff |-> !homing_complete_flag_ff)
      else $error("complete flag high while homing");

   a_table_one: assert property (@(posedge core_clk) disable iff (rst)
      $rose(homing_busy_ff) |->
      motion_cmd_ff.accel_time == $past(table_one.accel_time) &&
      motion_cmd_ff.decel_time == $past(table_one.decel_time))
      else $error("homing not using point table 1 times");

   a_direction: assert property (@(posedge core_clk) disable iff (rst)
      $rose(homing_busy_ff) |->
      motion_cmd_ff.direction == $past(params.homing_direction_param))
      else $error("homing started in the wrong direction");

   a_shift_stop: assert property (@(posedge core_clk) disable iff (rst)
      (state_ff == ST_WAIT_Z && z_pulse &&
       params.home_shift_param != `TRAVEL_ZERO && !dog_short)
      |=> state_ff == ST_SHIFT && motion_cmd_ff.run)
      else $error("home shift distance not applied");

endmodule

// file: hw/homing_cfg.svh
// Constants for the count type homing sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef HOMING_CFG_SVH
`define HOMING_CFG_SVH

`define METHOD_COUNT_TYPE   4'h1
`define DIR_INCREMENT       1'h0
`define DOG_ON_DETECTS      1'h1
`define DOG_MIN_MS          32'h0000_000A
`define CYCLES_PER_MS       32'h0001_86A0
`define POS_STEP            32'h0000_0001
`define TRAVEL_ZERO         32'h0000_0000
`define SPEED_STOP          16'h0000
`define DOG_CNT_ZERO        20'h0_0000
`define DOG_CNT_ONE         20'h0_0001

`endif

// file: hw/homing_pkg.sv
// Types shared by the homing sequencer files.
// Assumes homing_cfg.svh is on the include path.
package homing_pkg;

   // Parameters set by the host before a homing start
   typedef struct packed {
      logic [3:0]  homing_method_param;
      logic        homing_direction_param;
      logic        input_polarity_param;
      logic [15:0] homing_speed_param;
      logic [15:0] creep_speed_param;
      logic [31:0] home_shift_param;
      logic [31:0] home_address_param;
      logic [31:0] post_dog_travel_param;
   } homing_param_type;

   // Point table entry 1 time constants
   typedef struct packed {
      logic [15:0] accel_time;
      logic [15:0] decel_time;
   } accel_decel_type;

   // Mode selection inputs from the remote host
   typedef struct packed {
      logic       auto_manual_select;
      logic [4:0] point_table_select_low;
      logic [2:0] point_table_select_high;
      logic       pos_speed_source_select;
   } mode_select_type;

   // Motion command presented to the servo loop
   typedef struct packed {
      logic        run;
      logic        direction;
      logic [15:0] speed;
      logic [15:0] accel_time;
      logic [15:0] decel_time;
   } motion_cmd_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FAST,
      ST_TRAVEL,
      ST_WAIT_Z,
      ST_SHIFT
   } homing_state_type;

endpackage

// file: hw/dog_qualifier.sv
// Proximity dog front edge detector with minimum length check.
// Assumes dog_in is synchronous to core_clk.
`timescale 1ns/1ps
`include "homing_cfg.svh"

module dog_qualifier
#(
   parameter int DOG_MIN_CYCLES = `DOG_MIN_MS * `CYCLES_PER_MS
)
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Dog input and polarity
   input  wire logic dog_in,
   input  wire logic input_polarity_param,
   // Qualified events
   output logic      dog_front_ff,
   output logic      dog_short_ff
);

   logic        det;
   logic        det_prev_ff;
   logic        nxt_det_prev;
   logic [19:0] hold_cnt_ff;
   logic [19:0] nxt_hold_cnt;
   logic        nxt_dog_front;
   logic        nxt_dog_short;
   logic        counting_ff;
   logic        nxt_counting;

   always_comb
   begin
      // Polarity 1: ON means dog; polarity 0: OFF means dog
      det = (input_polarity_param == `DOG_ON_DETECTS) ? dog_in : ~dog_in;
      nxt_det_prev  = det;
      nxt_dog_front = det & ~det_prev_ff;
      nxt_dog_short = 1'b0;
      nxt_hold_cnt  = hold_cnt_ff;
      nxt_counting  = counting_ff;
      if (det & ~det_prev_ff)
      begin
         nxt_hold_cnt = `DOG_CNT_ONE;
         nxt_counting = 1'b1;
      end
      else if (counting_ff)
      begin
         if (!det)
         begin
            // Dog left before the minimum length
            nxt_dog_short = 1'b1;
            nxt_counting  = 1'b0;
         end
         else if (hold_cnt_ff >= 20'(DOG_MIN_CYCLES - 1))
            nxt_counting = 1'b0;
         else
            nxt_hold_cnt = hold_cnt_ff + `DOG_CNT_ONE;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         // Seen as detected, so a dog present at reset is no front
         det_prev_ff  <= 1'b1;
         hold_cnt_ff  <= `DOG_CNT_ZERO;
         counting_ff  <= 1'b0;
         dog_front_ff <= 1'b0;
         dog_short_ff <= 1'b0;
      end
      else
      begin
         det_prev_ff  <= nxt_det_prev;
         hold_cnt_ff  <= nxt_hold_cnt;
         counting_ff  <= nxt_counting;
         dog_front_ff <= nxt_dog_front;
         dog_short_ff <= nxt_dog_short;
      end
   end

   a_front_single: assert property (@(posedge core_clk) disable iff (rst)
      dog_front_ff |=> !dog_front_ff)
      else $error("dog front pulse lasted more than one cycle");

endmodule

// file: testbench/homing_host_model.sv
// Remote host model: selects manual homing mode, then pulses start.
// Assumes the bench holds go until the start pulse has gone by.
`timescale 1ns/1ps

module homing_host_model
(
   // Clock
   input  wire logic                   core_clk,
   // Requests from the bench
   input  wire logic                   go,
   input  wire logic                   bad_mode,
   // Host outputs
   output homing_pkg::mode_select_type mode_select,
   output logic                        start
);
   import homing_pkg::*;

   initial
   begin
      mode_select = '0;
      start       = 1'b0;
      forever
      begin
         @(posedge core_clk iff go);
         // Manual mode; bad_mode leaves one table select on
         mode_select <= '{1'b1, {4'h0, bad_mode}, 3'h0, 1'b1};
         repeat (4) @(posedge core_clk);
         start <= 1'b1;
         @(posedge core_clk);
         start <= 1'b0;
         @(posedge core_clk iff !go);
      end
   end
endmodule

// file: testbench/test_count_type_homing.sv
// Self-checking bench for the count type homing sequencer.
// Assumes homing_pkg and homing_host_model are compiled first.
`timescale 1ns/1ps

module test_count_type_homing;
   import homing_pkg::*;

   localparam int          DOG_MIN  = 20;
   localparam logic [15:0] HOME_SPD = 16'h0400;
   localparam logic [15:0] CREEP    = 16'h0040;
   localparam logic [15:0] ACC      = 16'h0064;
   localparam logic [15:0] DEC      = 16'h00C8;
   localparam logic [31:0] ADDR     = 32'h0000_1234;

   logic             core_clk;
   logic             rst;
   logic             start;
   logic             go;
   logic             bad_mode;
   logic             dog_in;
   logic             z_pulse;
   logic             move_step;
   mode_select_type  mode_select;
   homing_param_type params;
   accel_decel_type  table_one;
   motion_cmd_type   motion_cmd_ff;
   logic [31:0]      current_position_ff;
   logic             homing_complete_flag_ff;
   logic             homing_busy_ff;
   logic             homing_error_ff;
   int               miscompares;
   int               comparisons;

   count_type_homing #(.DOG_MIN_CYCLES(DOG_MIN)) u_count_type_homing
   (
      .core_clk                (core_clk),
      .rst                     (rst),
      .mode_select             (mode_select),
      .start                   (start),
      .params                  (params),
      .table_one               (table_one),
      .dog_in                  (dog_in),
      .z_pulse                 (z_pulse),
      .move_step               (move_step),
      .motion_cmd_ff           (motion_cmd_ff),
      .current_position_ff     (current_position_ff),
      .homing_complete_flag_ff (homing_complete_flag_ff),
      .homing_busy_ff          (homing_busy_ff),
      .homing_error_ff         (homing_error_ff)
   );

   homing_host_model u_homing_host_model
   (
      .core_clk    (core_clk),
      .go          (go),
      .bad_mode    (bad_mode),
      .mode_select (mode_select),
      .start       (start)
   );

   // ********************************
   // Shared tasks
   // ********************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         move_step <= 1'b1;
         @(posedge core_clk);
         move_step <= 1'b0;
      end
   endtask

   task automatic z_once;
      @(posedge core_clk);
      z_pulse <= 1'b1;
      @(posedge core_clk);
      z_pulse <= 1'b0;
   endtask

   // Host takes a fixed 6 cycles to start; 12 leaves the answer settled
   task automatic host_start(input logic bad);
      @(posedge core_clk);
      bad_mode <= bad;
      go       <= 1'b1;
      repeat (12) @(posedge core_clk);
      go <= 1'b0;
   endtask

   task automatic homing_run(input logic pol, input logic dir,
                             input int travel, input int shift);
      int i;
      @(posedge core_clk);
      params.input_polarity_param   <= pol;
      params.homing_direction_param <= dir;
      params.post_dog_travel_param  <= travel;
      params.home_shift_param       <= shift;
      dog_in                        <= ~pol;
      host_start(1'b0);
      check(homing_busy_ff, 32'h1);
      check(homing_complete_flag_ff, 32'h0);
      check(motion_cmd_ff.run, 32'h1);
      check(motion_cmd_ff.speed, HOME_SPD);
      check(motion_cmd_ff.direction, dir);
      check({motion_cmd_ff.accel_time, motion_cmd_ff.decel_time},
            {ACC, DEC});
      @(posedge core_clk);
      dog_in <= pol;
      repeat (4) @(posedge core_clk);
      check(motion_cmd_ff.speed, CREEP);
      if (travel > 0)
      begin
         // A Z before the travel is covered must not make home
         step(travel - 1);
         z_once();
         repeat (3) @(posedge core_clk);
         check(homing_busy_ff, 32'h1);
         step(1);
      end
      z_once();
      if (shift > 0)
      begin
         step(shift - 1);
         repeat (3) @(posedge core_clk);
         check(homing_complete_flag_ff, 32'h0);
         step(1);
      end
      for (i = 0; i < 10 && homing_complete_flag_ff !== 1'b1; i++)
         @(posedge core_clk);
      check(homing_complete_flag_ff, 32'h1);
      check(current_position_ff, ADDR);
      check(homing_busy_ff, 32'h0);
      check(motion_cmd_ff.run, 32'h0);
      check(homing_error_ff, 32'h0);
      @(posedge core_clk);
      dog_in <= ~pol;
   endtask

   // Dog released well before the minimum length while travelling
   task automatic short_dog;
      @(posedge core_clk);
      params.post_dog_travel_param <= 32'h0000_0008;
      dog_in                       <= 1'b0;
      host_start(1'b0);
      @(posedge core_clk);
      dog_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      dog_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      check(homing_error_ff, 32'h1);
      check(homing_busy_ff, 32'h0);
      check(motion_cmd_ff.run, 32'h0);
      check(homing_complete_flag_ff, 32'h0);
   endtask

   task automatic test_done;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ********************************
   // Clock, watchdog and sequence
   // ********************************
   initial
   begin
      core_clk = 1'b0;
      forever
         #5 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   initial
   begin
      rst                        = 1'b1;
      go                         = 1'b0;
      bad_mode                   = 1'b0;
      dog_in                     = 1'b0;
      z_pulse                    = 1'b0;
      move_step                  = 1'b0;
      miscompares                = 0;
      comparisons                = 0;
      params                     = '0;
      params.homing_method_param = 4'h2;
      params.homing_speed_param  = HOME_SPD;
      params.creep_speed_param   = CREEP;
      params.home_address_param  = ADDR;
      table_one                  = '{ACC, DEC};
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      check(homing_complete_flag_ff, 32'h0);
      host_start(1'b0);
      check(homing_busy_ff, 32'h0);
      params.homing_method_param <= 4'h1;
      host_start(1'b1);
      check(homing_busy_ff, 32'h0);
      homing_run(1'b1, 1'b0, 3, 0);
      short_dog();
      homing_run(1'b0, 1'b1, 0, 2);
      homing_run(1'b1, 1'b0, 5, 4);
      test_done();
   end
endmodule
